// *** pkg/fbps_pkg.sv ***
// Shared constants and types for the flash burst, protection and security controller
package fbps_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] DIV_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] PROT_OFS = 8'h10;
  localparam logic [7:0] OPT_OFS = 8'h14;
  localparam logic [7:0] ARR_OFS = 8'h18;
  // Nonvolatile byte locations in the flash map
  localparam logic [15:0] PROT_NV_ADDR = 16'hffbd;
  localparam logic [15:0] OPT_NV_ADDR = 16'hffbf;
  // Command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  // Field positions
  localparam int ST_CBEF = 7;
  localparam int ST_CCF = 6;
  localparam int ST_ACCERR = 5;
  localparam int ST_PVIOL = 4;
  localparam int CFG_KEY_ACCESS_BIT = 5;
  localparam int DIV_LOADED = 7;
  localparam int DIV_PRE8 = 6;
  localparam int PROT_DIS = 0;
  localparam int OPT_BACKDOOR_ENABLE_BIT = 7;
  localparam int OPT_NORED = 6;
  localparam logic [1:0] SEC_OPEN = 2'b10;
  localparam int ROW_BITS = 6;
  localparam logic [8:0] PAGE_ONES = 9'h1ff;
  localparam logic [15:0] VEC_LO = 16'hffc0;
  localparam logic [15:0] VEC_HI = 16'hfffd;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [3:0] KEY_LEN = 4'h8;
  // Command durations in flash clock periods
  localparam logic [14:0] T_BYTE = 15'h0009;
  localparam logic [14:0] T_BURST = 15'h0004;
  localparam logic [14:0] T_PAGE = 15'h0fa0;
  localparam logic [14:0] T_MASS = 15'h4e20;
  localparam logic [14:0] T_BLANK = 15'h0001;
  localparam logic [2:0] PRE8_MAX = 3'h7;

  typedef enum logic [3:0] {
    FBPS_IDLE = 4'b0001,
    FBPS_ADDR = 4'b0010,
    FBPS_CMD = 4'b0100,
    FBPS_QUEUED = 4'b1000
  } fbps_seq_t;

  typedef struct packed {
    logic valid;
    logic shortTime;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
  } fbps_op_t;
endpackage

// *** hdl/fbps_ctrl.sv ***
// Flash command sequencer with burst pump control, block protection, vector redirect and security
//
// Local design decision: register access over AHB-Lite.
module fbps_ctrl
  import fbps_pkg::*;
#(
  parameter logic [15:0] FLASH_BASE = 16'hf000,
  parameter logic [15:0] RAM_BASE = 16'h0060,
  parameter logic [15:0] RAM_TOP = 16'h015f,
  parameter logic [15:0] KEY_BASE = 16'hffb0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic debugAccess,
  input wire logic secureCode,
  input wire logic [7:0] protOptionByte,
  input wire logic [7:0] optionByte,
  input wire logic [63:0] backdoorKey,
  input wire logic stopMode,
  input wire logic blankCheckOk,
  input wire logic debugModePin,
  input wire logic [15:0] fetchAddr,
  output logic [15:0] vectorAddr,
  input wire logic memAccess,
  input wire logic [15:0] memAddr,
  output logic accessBlocked,
  output fbps_pkg::fbps_op_t arrayOp,
  output logic pumpOn,
  output logic debugEnable,
  output logic activeBackground
);
  import fbps_pkg::*;

  // Key block must be eight-byte aligned and the RAM window must not be empty
  if (KEY_BASE[2:0] != 3'h0 || RAM_TOP < RAM_BASE) begin : g_badParams
    $error("fbps_ctrl: bad address parameters");
  end

  fbps_seq_t seq_reg;
  fbps_op_t buf_reg, cur_reg, op_reg;
  logic wrPend_reg, dbgAcc_reg, secCode_reg;
  logic [7:0] regAddr_reg;
  logic [31:0] hrdata_reg;
  logic [7:0] div_reg, prot_reg, opt_reg;
  logic cbef_reg, accErr_reg, pviol_reg, key_access_bit_reg, unlocked_reg;
  logic keyOk_reg, run_reg, pump_reg, bgd_reg, pinMeta_reg, pin_reg;
  logic [3:0] keyIdx_reg;
  logic [14:0] rem_reg;
  logic [2:0] pre_reg;
  logic [5:0] divCnt_reg;
  logic [15:0] vect_reg;
  logic wDiv, wCfg, wCmd, wStat, wProt, wArr, keyWrite, cmdArr;
  logic errSet, launch, validCode, restricted, secure, tick, done, chain, start, progRun;
  logic protOn, someProt, allProt, blocked, midSeq;
  logic [15:0] arrAddr, lastOpen;
  logic [7:0] keyByte;

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      wrPend_reg <= 1'b0;
      regAddr_reg <= 8'h00;
      dbgAcc_reg <= 1'b0;
      secCode_reg <= 1'b0;
    end else begin
      wrPend_reg <= hsel & htrans[1] & hready & hwrite;
      regAddr_reg <= haddr[7:0];
      dbgAcc_reg <= debugAccess;
      secCode_reg <= secureCode;
    end
  end

  // Read data is captured in the address phase; unmapped offsets read zero
  always_ff @(posedge clock) begin
    if (srst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        DIV_OFS: hrdata_reg <= {24'h000000, div_reg};
        CFG_OFS: hrdata_reg <= {26'h0000000, key_access_bit_reg, 5'h00};
        CMD_OFS: hrdata_reg <= {24'h000000, buf_reg.cmd};
        STAT_OFS: hrdata_reg <= {24'h000000, cbef_reg, !run_reg && seq_reg != FBPS_QUEUED,
                                 accErr_reg, pviol_reg, 4'h0};
        PROT_OFS: hrdata_reg <= {24'h000000, prot_reg};
        OPT_OFS: hrdata_reg <= {24'h000000, opt_reg[7:2], secure ? opt_reg[1:0] : SEC_OPEN};
        default: hrdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      hrdata_reg <= 32'h0000_0000;
    end
  end

  assign wDiv = wrPend_reg && regAddr_reg == DIV_OFS;
  assign wCfg = wrPend_reg && regAddr_reg == CFG_OFS;
  assign wCmd = wrPend_reg && regAddr_reg == CMD_OFS;
  assign wStat = wrPend_reg && regAddr_reg == STAT_OFS;
  assign wProt = wrPend_reg && regAddr_reg == PROT_OFS;
  assign wArr = wrPend_reg && regAddr_reg == ARR_OFS;
  assign arrAddr = hwdata[23:8];

  // Security state
  assign secure = opt_reg[1:0] != SEC_OPEN && !unlocked_reg;
  assign debugEnable = !secure;
  assign activeBackground = bgd_reg;
  assign accessBlocked = secure && memAccess && (dbgAcc_reg || !secCode_reg) &&
                         (memAddr >= FLASH_BASE || (memAddr >= RAM_BASE && memAddr <= RAM_TOP));

  // Not reset: the synchronised pin level must settle while reset is still held
  always_ff @(posedge clock) begin
    pinMeta_reg <= debugModePin;
    pin_reg <= pinMeta_reg;
  end

  // Pin level seen while reset is held is what counts at its release
  always_ff @(posedge clock) begin
    if (srst) begin
      bgd_reg <= !pin_reg;
    end
  end

  // Option and protection bytes reload on every reset
  always_ff @(posedge clock) begin
    if (srst) begin
      opt_reg <= optionByte;
      prot_reg <= protOptionByte;
    end else if (wProt && dbgAcc_reg && !midSeq) begin
      prot_reg <= hwdata[7:0];
    end
  end

  // Protection boundary
  assign lastOpen = {prot_reg[7:1], PAGE_ONES};
  assign protOn = !prot_reg[PROT_DIS];
  assign someProt = protOn && lastOpen != ALL_ONES;
  assign allProt = protOn && lastOpen < FLASH_BASE;
  always_comb begin
    case (buf_reg.cmd)
      CMD_MASS: blocked = someProt;
      CMD_BLANK: blocked = 1'b0;
      default: blocked = protOn && buf_reg.addr > lastOpen;
    endcase
  end

  // Vector redirection to the row just below the protected area
  always_ff @(posedge clock) begin
    if (srst) begin
      vect_reg <= 16'h0000;
    end else if (!opt_reg[OPT_NORED] && someProt && !allProt && fetchAddr >= VEC_LO && fetchAddr <= VEC_HI) begin
      vect_reg <= {lastOpen[15:ROW_BITS], fetchAddr[ROW_BITS-1:0]};
    end else begin
      vect_reg <= fetchAddr;
    end
  end
  assign vectorAddr = vect_reg;

  // Backdoor key: only secure code may open key access; a key byte written by any other source spoils the key
  assign keyWrite = wArr && key_access_bit_reg && arrAddr[15:3] == KEY_BASE[15:3];
  assign keyByte = backdoorKey[{arrAddr[2:0], 3'b000} +: 8];
  assign cmdArr = wArr && !keyWrite;

  always_ff @(posedge clock) begin
    if (srst) begin
      key_access_bit_reg <= 1'b0;
      keyIdx_reg <= 4'h0;
      keyOk_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else begin
      if (wCfg && !dbgAcc_reg && secCode_reg && !midSeq) begin
        key_access_bit_reg <= hwdata[CFG_KEY_ACCESS_BIT];
        if (hwdata[CFG_KEY_ACCESS_BIT] && !key_access_bit_reg) begin
          keyIdx_reg <= 4'h0;
          keyOk_reg <= 1'b1;
        end
        if (!hwdata[CFG_KEY_ACCESS_BIT] && key_access_bit_reg && keyOk_reg && keyIdx_reg == KEY_LEN && opt_reg[OPT_BACKDOOR_ENABLE_BIT]) begin
          unlocked_reg <= 1'b1;
        end
      end
      if (keyWrite) begin
        if (dbgAcc_reg || !secCode_reg || keyIdx_reg == KEY_LEN || arrAddr[2:0] != keyIdx_reg[2:0] ||
            hwdata[7:0] != keyByte) begin
          keyOk_reg <= 1'b0;
        end
        if (keyIdx_reg != KEY_LEN) begin
          keyIdx_reg <= keyIdx_reg + 4'h1;
        end
      end
      if (done && cur_reg.cmd == CMD_BLANK && blankCheckOk) begin
        unlocked_reg <= 1'b1;
      end
    end
  end

  // Command protocol checks
  assign midSeq = seq_reg == FBPS_ADDR || seq_reg == FBPS_CMD;
  assign validCode = hwdata[7:0] == CMD_BLANK || hwdata[7:0] == CMD_BYTE || hwdata[7:0] == CMD_BURST ||
                     hwdata[7:0] == CMD_PAGE || hwdata[7:0] == CMD_MASS;
  assign restricted = hwdata[7:0] == CMD_BYTE || hwdata[7:0] == CMD_BURST || hwdata[7:0] == CMD_PAGE;
  assign progRun = run_reg && cur_reg.cmd != CMD_BLANK;

  always_comb begin
    errSet = 1'b0;
    if (cmdArr && !accErr_reg && (!div_reg[DIV_LOADED] || !cbef_reg || seq_reg != FBPS_IDLE)) begin
      errSet = 1'b1;
    end
    if (wCmd && (seq_reg != FBPS_ADDR || !validCode || (secure && dbgAcc_reg && restricted))) begin
      errSet = 1'b1;
    end
    if ((wDiv || wCfg || wProt) && midSeq) begin
      errSet = 1'b1;
    end
    if (wStat && midSeq && (!hwdata[ST_CBEF] || seq_reg == FBPS_ADDR)) begin
      errSet = 1'b1;
    end
    if (stopMode && progRun) begin
      errSet = 1'b1;
    end
  end

  assign launch = wStat && seq_reg == FBPS_CMD && hwdata[ST_CBEF] && !errSet;

  always_ff @(posedge clock) begin
    if (srst) begin
      accErr_reg <= 1'b0;
      pviol_reg <= 1'b0;
      div_reg <= 8'h00;
    end else begin
      if (errSet) begin
        accErr_reg <= 1'b1;
      end else if (wStat && hwdata[ST_ACCERR]) begin
        accErr_reg <= 1'b0;
      end
      if (launch && blocked) begin
        pviol_reg <= 1'b1;
      end else if (wStat && hwdata[ST_PVIOL]) begin
        pviol_reg <= 1'b0;
      end
      if (wDiv && !div_reg[DIV_LOADED] && !accErr_reg && !midSeq) begin
        div_reg <= {1'b1, hwdata[6:0]};
      end
    end
  end

  // Sequence: array write, command code, launch, then wait for the engine
  always_ff @(posedge clock) begin
    if (srst) begin
      seq_reg <= FBPS_IDLE;
      buf_reg <= '0;
      cbef_reg <= 1'b1;
    end else if (errSet) begin
      seq_reg <= FBPS_IDLE;
      cbef_reg <= 1'b1;
    end else begin
      case (seq_reg)
        FBPS_IDLE: begin
          if (cmdArr && !accErr_reg) begin
            seq_reg <= FBPS_ADDR;
            buf_reg.addr <= arrAddr;
            buf_reg.data <= hwdata[7:0];
          end
        end
        FBPS_ADDR: begin
          if (wCmd) begin
            seq_reg <= FBPS_CMD;
            buf_reg.cmd <= hwdata[7:0];
          end
        end
        FBPS_CMD: begin
          if (launch) begin
            seq_reg <= blocked ? FBPS_IDLE : FBPS_QUEUED;
            cbef_reg <= blocked;
          end
        end
        FBPS_QUEUED: begin
          if (start) begin
            seq_reg <= FBPS_IDLE;
            cbef_reg <= 1'b1;
          end
        end
        default: seq_reg <= FBPS_IDLE;
      endcase
    end
  end

  // Flash clock tick from the bus clock, optional divide by eight
  always_ff @(posedge clock) begin
    if (srst) begin
      pre_reg <= 3'h0;
      divCnt_reg <= 6'h00;
    end else if (!div_reg[DIV_PRE8] || pre_reg == PRE8_MAX) begin
      pre_reg <= 3'h0;
      divCnt_reg <= divCnt_reg == div_reg[5:0] ? 6'h00 : divCnt_reg + 6'h01;
    end else begin
      pre_reg <= pre_reg + 3'h1;
    end
  end
  assign tick = (!div_reg[DIV_PRE8] || pre_reg == PRE8_MAX) && divCnt_reg == div_reg[5:0];

  // Engine with burst chaining
  assign done = run_reg && tick && rem_reg == 15'h0001;
  assign chain = cur_reg.cmd == CMD_BURST && buf_reg.cmd == CMD_BURST && seq_reg == FBPS_QUEUED &&
                 buf_reg.addr[15:ROW_BITS] == cur_reg.addr[15:ROW_BITS] &&
                 buf_reg.addr[ROW_BITS-1:0] != '0;
  assign start = seq_reg == FBPS_QUEUED && !errSet && (!run_reg || (done && chain));

  always_ff @(posedge clock) begin
    if (srst) begin
      run_reg <= 1'b0;
      pump_reg <= 1'b0;
      rem_reg <= 15'h0000;
      cur_reg <= '0;
    end else if (stopMode && progRun) begin
      run_reg <= 1'b0;
      pump_reg <= 1'b0;
    end else if (start) begin
      run_reg <= 1'b1;
      pump_reg <= buf_reg.cmd != CMD_BLANK;
      cur_reg <= buf_reg;
      case (buf_reg.cmd)
        CMD_BURST: rem_reg <= run_reg && chain ? T_BURST : T_BYTE;
        CMD_BYTE: rem_reg <= T_BYTE;
        CMD_PAGE: rem_reg <= T_PAGE;
        CMD_MASS: rem_reg <= T_MASS;
        default: rem_reg <= T_BLANK;
      endcase
    end else if (done) begin
      run_reg <= 1'b0;
      pump_reg <= 1'b0;
    end else if (run_reg && tick) begin
      rem_reg <= rem_reg - 15'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      op_reg <= '0;
    end else if (start) begin
      op_reg <= buf_reg;
      op_reg.valid <= 1'b1;
      op_reg.shortTime <= run_reg && chain;
    end else begin
      op_reg.valid <= 1'b0;
    end
  end
  assign arrayOp = op_reg;
  assign pumpOn = pump_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  pump_chain_a: assert property (done && chain && !errSet |=> pumpOn && arrayOp.valid && arrayOp.shortTime)
    else $error("pump dropped during burst chain");
  row_start_a: assert property (arrayOp.valid && arrayOp.addr[5:0] == 6'h00 |-> !arrayOp.shortTime)
    else $error("row start used burst time");
  first_std_a: assert property ($rose(run_reg) && !$past(run_reg) |-> !arrayOp.shortTime)
    else $error("first byte not standard time");
  pump_off_a: assert property (done && !(chain && !errSet) |=> !pumpOn)
    else $error("pump left on with nothing queued");
  err_block_a: assert property (accErr_reg && seq_reg == FBPS_IDLE |=> seq_reg == FBPS_IDLE)
    else $error("command accepted with access error set");
  no_div_a: assert property (cmdArr && !div_reg[DIV_LOADED] && !accErr_reg |=> accErr_reg)
    else $error("array write before divider not flagged");
  busy_arr_a: assert property (cmdArr && !cbef_reg |=> accErr_reg)
    else $error("array write with full buffer not flagged");
  bad_code_a: assert property (wCmd && !validCode |=> accErr_reg && seq_reg == FBPS_IDLE)
    else $error("illegal command code not flagged");
  stop_abort_a: assert property (stopMode && progRun |=> !run_reg && !pumpOn && accErr_reg)
    else $error("stop did not abort command");
  prot_hold_a: assert property (wProt && !dbgAcc_reg |=> $stable(prot_reg))
    else $error("application changed protection");
  blank_open_a: assert property (done && cur_reg.cmd == CMD_BLANK && blankCheckOk |=> !secure [*3])
    else $error("blank check did not unlock");
endmodule

// *** tb/fbps_host.sv ***
// Bus master model standing in for the processor or the debug controller
module fbps_host (
  input wire logic clock,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic debugAccess,
  output logic secureCode
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    debugAccess = 1'b0;
    secureCode = 1'b1;
  end
  // Source changes between transfers only, never inside one
  task automatic source(input logic dbg, input logic sec);
    @(posedge clock);
    debugAccess <= dbg;
    secureCode <= sec;
  endtask
  // One whole-word transfer; an idle cycle always precedes it, keeping key writes apart
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    hwdata <= ~hwdata;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the flash sequencer, protection and security controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fbps_pkg::*;
  localparam logic [15:0] FLASH_LO = 16'hf000;
  logic clock, srst, hready, hresp, hsel, hwrite, debugAccess, secureCode, stopMode, blankCheckOk;
  logic debugModePin, memAccess, accessBlocked, pumpOn, debugEnable, activeBackground, pumpPrev;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] protOptionByte, optionByte, c;
  logic [63:0] backdoorKey;
  logic [15:0] fetchAddr, vectorAddr, memAddr, a;
  fbps_op_t arrayOp;
  fbps_op_t ops[$];
  int n_fail, checked, seed, falls, i, k;

  fbps_ctrl #(.FLASH_BASE(FLASH_LO)) u_dut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .debugAccess(debugAccess), .secureCode(secureCode),
    .protOptionByte(protOptionByte), .optionByte(optionByte), .backdoorKey(backdoorKey), .stopMode(stopMode),
    .blankCheckOk(blankCheckOk), .debugModePin(debugModePin), .fetchAddr(fetchAddr), .vectorAddr(vectorAddr),
    .memAccess(memAccess), .memAddr(memAddr), .accessBlocked(accessBlocked), .arrayOp(arrayOp),
    .pumpOn(pumpOn), .debugEnable(debugEnable), .activeBackground(activeBackground));
  fbps_host u_host (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .debugAccess(debugAccess),
    .secureCode(secureCode));

  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (arrayOp.valid === 1'b1) ops.push_back(arrayOp);
    if (pumpPrev === 1'b1 && pumpOn === 1'b0) falls++;
    pumpPrev <= pumpOn;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    u_host.xfer(1'b1, ofs, d, x);
  endtask
  task automatic rd(input logic [7:0] ofs);
    u_host.xfer(1'b0, ofs, 32'h0, r);
  endtask
  task automatic arr(input logic [15:0] ad, input logic [7:0] d);
    wr(ARR_OFS, {8'h00, ad, d});
  endtask
  // Next command may only be built once the buffer has been handed to the engine
  task automatic ready_wait;
    int n;
    n = 0;
    rd(STAT_OFS);
    while (r[ST_CBEF] !== 1'b1 && n < 20000) begin
      rd(STAT_OFS);
      n++;
    end
    chk("buffer empty", 32'h1, {31'h0, r[ST_CBEF]});
  endtask
  task automatic launch(input logic [15:0] ad, input logic [7:0] d, input logic [7:0] cm);
    ready_wait;
    arr(ad, d);
    wr(CMD_OFS, {24'h0, cm});
    wr(STAT_OFS, 32'h80);
  endtask
  task automatic err(input logic e);
    rd(STAT_OFS);
    chk("access error", {31'h0, e}, {31'h0, r[ST_ACCERR]});
  endtask
  task automatic clr;
    wr(STAT_OFS, 32'h30);
  endtask
  task automatic done_wait;
    int n;
    n = 0;
    rd(STAT_OFS);
    while (r[ST_CCF] !== 1'b1 && n < 20000) begin
      rd(STAT_OFS);
      n++;
    end
    chk("complete", 32'h1, {31'h0, r[ST_CCF]});
  endtask
  task automatic rst(input logic [7:0] p, input logic [7:0] o, input logic pin);
    @(posedge clock);
    srst <= 1'b1;
    protOptionByte <= p;
    optionByte <= o;
    debugModePin <= pin;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    ops.delete();
  endtask
  // Expected vector: interrupt vectors move to the row just below the protected block
  function automatic logic [15:0] redir(input logic [15:0] f, input logic [7:0] p, input logic [7:0] o);
    logic [15:0] last;
    last = {p[7:1], PAGE_ONES};
    if (!o[OPT_NORED] && !p[PROT_DIS] && last >= FLASH_LO && last != ALL_ONES && f >= VEC_LO && f <= VEC_HI)
      return {last[15:6], f[5:0]};
    return f;
  endfunction
  task automatic test_done;
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(100000 * 25);
    n_fail++;
    test_done;
  end

  initial begin
    clock = 1'b0;
    srst = 1'b1;
    stopMode = 1'b0;
    blankCheckOk = 1'b0;
    debugModePin = 1'b1;
    fetchAddr = 16'h0;
    memAccess = 1'b0;
    memAddr = 16'h0;
    protOptionByte = 8'hff;
    optionByte = 8'h02;
    pumpPrev = 1'b0;
    seed = 57;
    backdoorKey = {$random(seed), $random(seed)};
    rst(8'hff, 8'h02, 1'b1);
    chk("background", 32'h0, {31'h0, activeBackground});
    arr(16'hf000, 8'h11);
    err(1'b1);
    clr;
    err(1'b0);
    wr(DIV_OFS, 32'h01);
    rd(DIV_OFS);
    chk("divider loaded", 32'h1, {31'h0, r[DIV_LOADED]});
    chk("response", 32'h0, {31'h0, hresp});
    for (k = 0; k < 5; k++) begin
      c = (k == 0) ? CMD_BLANK : (k == 1) ? CMD_BYTE : (k == 2) ? CMD_BURST : (k == 3) ? CMD_PAGE : CMD_MASS;
      a = {7'h78, 9'($random(seed))};
      ops.delete();
      launch(a, 8'($random(seed)), c);
      done_wait;
      chk("op count", 32'h1, 32'(ops.size()));
      chk("op code", {24'h0, c}, {24'h0, ops[0].cmd});
      chk("op address", {16'h0, a}, {16'h0, ops[0].addr});
      chk("pump idle", 32'h0, {31'h0, pumpOn});
    end
    ops.delete();
    falls = 0;
    launch(16'hf07e, 8'h5a, CMD_BURST);
    launch(16'hf07f, 8'ha5, CMD_BURST);
    launch(16'hf080, 8'h3c, CMD_BURST);
    done_wait;
    chk("burst ops", 32'h3, 32'(ops.size()));
    chk("burst times", 32'h2, {29'h0, ops[0].shortTime, ops[1].shortTime, ops[2].shortTime});
    chk("pump drops", 32'h2, 32'(falls));
    ops.delete();
    for (k = 0; k < 5; k++) begin
      arr(16'hf100, 8'h00);
      case (k)
        0: arr(16'hf101, 8'h00);
        1: begin
          wr(CMD_OFS, {24'h0, CMD_BYTE});
          wr(CMD_OFS, {24'h0, CMD_BYTE});
        end
        2: wr(CFG_OFS, 32'h0);
        3: begin
          wr(CMD_OFS, {24'h0, CMD_BYTE});
          wr(CFG_OFS, 32'h0);
        end
        default: wr(STAT_OFS, 32'h0);
      endcase
      err(1'b1);
      if (k == 0) launch(16'hf102, 8'h00, CMD_BYTE);
      clr;
      err(1'b0);
    end
    for (k = 0; k < 3; k++) begin
      c = 8'($random(seed));
      if (c == CMD_BLANK || c == CMD_BYTE || c == CMD_BURST || c == CMD_PAGE || c == CMD_MASS) c = 8'hff;
      arr(16'hf110, 8'h00);
      wr(CMD_OFS, {24'h0, c});
      err(1'b1);
      clr;
    end
    chk("no stray ops", 32'h0, 32'(ops.size()));
    launch(16'hf200, 8'h00, CMD_PAGE);
    launch(16'hf300, 8'h00, CMD_BYTE);
    arr(16'hf301, 8'h00);
    err(1'b1);
    clr;
    repeat (30) @(posedge clock);
    stopMode <= 1'b1;
    repeat (3) @(posedge clock);
    stopMode <= 1'b0;
    err(1'b1);
    chk("pump after stop", 32'h0, {31'h0, pumpOn});
    clr;
    rst(8'hfc, 8'h02, 1'b1);
    wr(DIV_OFS, 32'h01);
    for (k = 0; k < 5; k++) begin
      a = (k == 0) ? 16'hffc0 : (k == 1) ? 16'hffe0 : (k == 2) ? 16'hfffd : (k == 3) ? 16'hfffe : 16'hff00;
      fetchAddr <= a;
      repeat (2) @(posedge clock);
      chk("vector", {16'h0, redir(a, 8'hfc, 8'h02)}, {16'h0, vectorAddr});
    end
    launch(16'hfe10, 8'h00, CMD_BYTE);
    repeat (40) @(posedge clock);
    rd(STAT_OFS);
    chk("protect violation", 32'h1, {31'h0, r[ST_PVIOL]});
    clr;
    launch(16'hfdff, 8'h00, CMD_BYTE);
    done_wait;
    chk("boundary ops", 32'h1, 32'(ops.size()));
    wr(PROT_OFS, 32'hff);
    rd(PROT_OFS);
    chk("protection app", 32'hfc, r);
    u_host.source(1'b1, 1'b0);
    wr(PROT_OFS, 32'hff);
    rd(PROT_OFS);
    chk("protection debug", 32'hff, r);
    rst(8'hff, 8'h83, 1'b0);
    chk("background", 32'h1, {31'h0, activeBackground});
    chk("debug enable", 32'h0, {31'h0, debugEnable});
    wr(DIV_OFS, 32'h01);
    arr(16'hf100, 8'h00);
    wr(CMD_OFS, {24'h0, CMD_BYTE});
    err(1'b1);
    clr;
    memAccess <= 1'b1;
    memAddr <= 16'hf100;
    @(posedge clock);
    chk("blocked", 32'h1, {31'h0, accessBlocked});
    wr(CFG_OFS, 32'h20);
    for (i = 0; i < 8; i++) arr(16'hffb0 + 16'(i), backdoorKey[8*i+:8]);
    wr(CFG_OFS, 32'h0);
    @(posedge clock);
    chk("debug key", 32'h0, {31'h0, debugEnable});
    u_host.source(1'b0, 1'b1);
    wr(CFG_OFS, 32'h20);
    for (i = 0; i < 8; i++) arr(16'hffb0 + 16'(i), backdoorKey[8*i+:8]);
    wr(CFG_OFS, 32'h0);
    rd(OPT_OFS);
    chk("unlocked bits", 32'h2, {30'h0, r[1:0]});
    chk("unlocked", 32'h1, {31'h0, debugEnable});
    chk("open access", 32'h0, {31'h0, accessBlocked});
    rst(8'hff, 8'h03, 1'b1);
    blankCheckOk <= 1'b1;
    u_host.source(1'b1, 1'b0);
    wr(DIV_OFS, 32'h01);
    launch(16'hf000, 8'h00, CMD_BLANK);
    done_wait;
    chk("blank unlock", 32'h1, {31'h0, debugEnable});
    test_done;
  end
endmodule
